// file: hw/bcrb_pkg.sv
/*
 * Constants of the backlight configuration register bank: register offsets,
 * field positions, power-on values, serial address and protocol states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bcrb_pkg;

    localparam int REG_W = 8;
    localparam int NUM_CFG = 12;
    localparam logic [7:0] MAP_TOP = 8'h0f;
    localparam logic [7:0] UNMAPPED_READ = 8'hff;

    localparam logic [7:0] OFS_LOOP_GAIN_BOOST_OVP_CONTROL = 8'h00;
    localparam logic [7:0] OFS_BOOST_LIMIT_FREQUENCY_CONFIG = 8'h01;
    localparam logic [7:0] OFS_BRIGHTNESS_RAMP_STEP_PERIOD = 8'h02;
    localparam logic [7:0] OFS_DIMMING_CURVE_MAX_CURRENT = 8'h03;
    localparam logic [7:0] OFS_STRING_ENABLE_MASK = 8'h04;
    localparam logic [7:0] OFS_BRIGHTNESS_LOW_BITS = 8'h05;
    localparam logic [7:0] OFS_BRIGHTNESS_HIGH_BITS = 8'h06;
    localparam logic [7:0] OFS_CURRENT_SOURCE_PWM_CONFIG = 8'h07;
    localparam logic [7:0] OFS_STANDBY_SOFT_RESET_CONTROL = 8'h08;
    localparam logic [7:0] OFS_DIM_INPUT_FILTER_CONFIG = 8'h09;
    localparam logic [7:0] OFS_REGULATOR_INIT_CURRENT_TRIM = 8'h0a;
    localparam logic [7:0] OFS_PUMP_RATIO_FREQUENCY_CONFIG = 8'h0b;
    localparam logic [7:0] OFS_NVM_CHECKSUM_LOW = 8'h0c;
    localparam logic [7:0] OFS_NVM_CHECKSUM_HIGH = 8'h0d;
    localparam logic [7:0] OFS_FAULT_FLAGS = 8'h0e;
    localparam logic [7:0] OFS_NVM_WRITE_AND_OPEN_FLAGS = 8'h0f;

    // Factory values of 0x00..0x0b, index 0 in the low byte
    localparam logic [NUM_CFG-1:0][7:0] CFG_RESET = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h32, 8'h00, 8'h53, 8'he0};

    // Fields of loop_gain_boost_ovp_control
    localparam int LOOP_GAIN_MSB = 7;
    localparam int LOOP_GAIN_LSB = 5;
    localparam int BOOST_MODE_BIT = 4;
    localparam int OVP_MSB = 3;
    localparam int OVP_LSB = 0;

    // Fields of nvm_write_and_open_flags
    localparam int NVM_CMD_MSB = 7;
    localparam int NVM_CMD_LSB = 3;
    localparam logic [4:0] NVM_CMD_PROGRAM = 5'h12;
    localparam logic [4:0] NVM_CMD_IDLE = 5'h00;

    // Serial address: upper bits fixed, low three from the strap pin
    localparam logic [3:0] ADDR_UPPER = 4'h6;
    localparam logic [1:0] STRAP_GROUND = 2'h0;
    localparam logic [1:0] STRAP_FLOAT = 2'h1;
    localparam logic [1:0] STRAP_SUPPLY = 2'h2;
    localparam logic [2:0] ADDR_LOW_GROUND = 3'h0;
    localparam logic [2:0] ADDR_LOW_FLOAT = 3'h2;
    localparam logic [2:0] ADDR_LOW_SUPPLY = 3'h5;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_CLOCKED = 4'h1;

    typedef enum logic [3:0] {
        BCRB_IDLE = 4'h0,
        BCRB_ADDR = 4'h1,
        BCRB_ADDR_ACK = 4'h3,
        BCRB_OFFSET = 4'h2,
        BCRB_OFFSET_ACK = 4'h6,
        BCRB_WDATA = 4'h7,
        BCRB_WDATA_ACK = 4'h5,
        BCRB_RDATA = 4'h4,
        BCRB_RDATA_ACK = 4'hc
    } bcrb_state_t;

endpackage

// file: hw/bcrb_line_if.sv
/*
 * Carrier between the line sensing module and the protocol logic.
 * Assumes a single clock shared by both ends.
 */
`timescale 1ns/1ns
interface bcrb_line_if;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic sdaLevel;

    modport sense (output sclRise, output sclFall, output startSeen, output stopSeen,
        output sdaLevel);
    modport proto (input sclRise, input sclFall, input startSeen, input stopSeen,
        input sdaLevel);
endinterface

// file: hw/bcrb_line_sense.sv
/*
 * Edge and bus condition detection on the serial clock and data lines.
 * Assumes both lines are already synchronous to the clock.
 */
`timescale 1ns/1ns
module bcrb_line_sense (
    input wire logic clock,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sdaIn,
    bcrb_line_if.sense line
);
    logic sclLast;
    logic sdaLast;

    // Idle bus is high on both lines, so reset to high avoids a false clock rise
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sclLast <= 1'b1;
            sdaLast <= 1'b1;
        end else begin
            sclLast <= scl;
            sdaLast <= sdaIn;
        end
    end

    assign line.sclRise = scl & ~sclLast;
    assign line.sclFall = ~scl & sclLast;
    assign line.startSeen = scl & sclLast & sdaLast & ~sdaIn;
    assign line.stopSeen = scl & sclLast & ~sdaLast & sdaIn;
    assign line.sdaLevel = sdaIn;
endmodule

// file: hw/bcrb_top.sv
/*
 * Register bank of a backlight boost driver, reached as a serial bus slave.
 * Assumes the master keeps to the bus protocol and that scl and sdaIn are
 * synchronous to clock; the data line is open drain, driven low only.
 */
// Function
// [RULE_01] With strap grounded, answer seven-bit address 0110000, byte 0x60 with direction.
// [RULE_02] Offset zero resets to 0xE0; reset values are factory defaults.
// [RULE_03] Offset zero bits 7..5 select loop gain, 000 highest, 2 dB steps.
// [RULE_04] Bit 4: 0 discontinuous switching, 1 forced continuous allowing negative current.
// [RULE_05] Bits 3..0: over-voltage threshold 47.5V at 0000, 1.875V lower per step.
// [RULE_06] Single write is start, address, offset, data; each byte acknowledged.
// [RULE_07] Written byte lands on the falling edge ending its acknowledge.
// [RULE_08] Reads outside the register map return FFh.
`timescale 1ns/1ns
module bcrb_top (
    input wire logic clock,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [1:0] addrStrap,
    input wire logic [7:0] checksumLow,
    input wire logic [7:0] checksumHigh,
    input wire logic [7:0] faultFlags,
    input wire logic nvmWriteDone,
    input wire logic nvmCrcOk,
    input wire logic ledOpen,
    output logic [2:0] loopGainSelect,
    output logic continuousConduction,
    output logic [3:0] overvoltageThresholdCode,
    output logic [bcrb_pkg::NUM_CFG*bcrb_pkg::REG_W-1:0] configRegs,
    output logic nvmProgramBusy
);
    bcrb_line_if line ();

    bcrb_line_sense u_sense (
        .clock(clock),
        .resetn(resetn),
        .scl(scl),
        .sdaIn(sdaIn),
        .line(line)
    );

    bcrb_pkg::bcrb_state_t state;
    logic [3:0] bitCount;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic [7:0] pointer;
    logic [6:0] ownAddress;
    logic [bcrb_pkg::NUM_CFG-1:0][7:0] cfg;
    logic [4:0] nvmCommand;
    logic byteDone;
    logic ackClocked;
    logic addressHit;
    logic readRequest;
    logic writeStrobe;
    logic masterAcked;
    logic ackPhase;
    logic [7:0] readByte;

    function automatic logic [2:0] strapLow(input logic [1:0] code);
        case (code)
            bcrb_pkg::STRAP_GROUND: strapLow = bcrb_pkg::ADDR_LOW_GROUND;
            bcrb_pkg::STRAP_FLOAT: strapLow = bcrb_pkg::ADDR_LOW_FLOAT;
            bcrb_pkg::STRAP_SUPPLY: strapLow = bcrb_pkg::ADDR_LOW_SUPPLY;
            default: strapLow = bcrb_pkg::ADDR_LOW_GROUND;
        endcase
    endfunction

    function automatic logic [7:0] readMux(input logic [7:0] ofs);
        if (ofs < bcrb_pkg::OFS_NVM_CHECKSUM_LOW) begin
            readMux = cfg[ofs[3:0]];
        end else begin
            case (ofs)
                bcrb_pkg::OFS_NVM_CHECKSUM_LOW: readMux = checksumLow;
                bcrb_pkg::OFS_NVM_CHECKSUM_HIGH: readMux = checksumHigh;
                bcrb_pkg::OFS_FAULT_FLAGS: readMux = faultFlags;
                bcrb_pkg::OFS_NVM_WRITE_AND_OPEN_FLAGS:
                    readMux = {nvmCommand, nvmWriteDone, nvmCrcOk, ledOpen};
                default: readMux = bcrb_pkg::UNMAPPED_READ; // [RULE_08]
            endcase
        end
    endfunction

    function automatic logic isAckPhase(input bcrb_pkg::bcrb_state_t st);
        case (st)
            bcrb_pkg::BCRB_ADDR_ACK,
            bcrb_pkg::BCRB_OFFSET_ACK,
            bcrb_pkg::BCRB_WDATA_ACK,
            bcrb_pkg::BCRB_RDATA_ACK: isAckPhase = 1'b1;
            default: isAckPhase = 1'b0;
        endcase
    endfunction

    // A process, not a continuous assignment, so register and input changes re-evaluate it
    always_comb begin
        readByte = readMux(pointer);
    end

    // The strap is caught while reset is held, so later pin noise cannot move the address
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ownAddress <= {bcrb_pkg::ADDR_UPPER, strapLow(addrStrap)}; // [RULE_01]
        end
    end

    assign byteDone = line.sclFall && (bitCount == bcrb_pkg::BITS_PER_BYTE);
    assign ackPhase = isAckPhase(state);
    // Qualified by state, since the first data bit of a byte also leaves the count at one
    assign ackClocked = line.sclFall && ackPhase && (bitCount == bcrb_pkg::ACK_CLOCKED);
    assign addressHit = (shiftIn[7:1] == ownAddress); // [RULE_01]
    assign readRequest = shiftIn[0];
    assign writeStrobe = (state == bcrb_pkg::BCRB_WDATA_ACK) && ackClocked; // [RULE_07]

    // Bit counter: data bits count up to eight, the acknowledge clock counts one
    always_ff @(posedge clock) begin
        if (!resetn) begin
            bitCount <= 4'h0;
        end else if (line.startSeen || line.stopSeen || byteDone || ackClocked) begin
            bitCount <= 4'h0;
        end else if (line.sclRise) begin
            bitCount <= bitCount + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            shiftIn <= 8'h00;
        end else if (line.sclRise && !ackPhase) begin
            // Acknowledge clock is not shifted, so the byte stays whole until its end
            shiftIn <= {shiftIn[6:0], line.sdaLevel};
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            masterAcked <= 1'b0;
        end else if (line.sclRise && state == bcrb_pkg::BCRB_RDATA_ACK) begin
            masterAcked <= ~line.sdaLevel;
        end
    end

    // Protocol sequence; a start anywhere restarts address reception
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= bcrb_pkg::BCRB_IDLE;
        end else if (line.startSeen) begin
            state <= bcrb_pkg::BCRB_ADDR;
        end else if (line.stopSeen) begin
            state <= bcrb_pkg::BCRB_IDLE;
        end else begin
            case (state)
                bcrb_pkg::BCRB_IDLE: state <= bcrb_pkg::BCRB_IDLE;
                bcrb_pkg::BCRB_ADDR: begin
                    if (byteDone) begin
                        state <= addressHit ? bcrb_pkg::BCRB_ADDR_ACK : bcrb_pkg::BCRB_IDLE;
                    end
                end
                bcrb_pkg::BCRB_ADDR_ACK: begin
                    if (ackClocked) begin
                        state <= readRequest ? bcrb_pkg::BCRB_RDATA : bcrb_pkg::BCRB_OFFSET;
                    end
                end
                bcrb_pkg::BCRB_OFFSET: begin
                    if (byteDone) begin
                        state <= bcrb_pkg::BCRB_OFFSET_ACK; // [RULE_06]
                    end
                end
                bcrb_pkg::BCRB_OFFSET_ACK: begin
                    if (ackClocked) begin
                        state <= bcrb_pkg::BCRB_WDATA;
                    end
                end
                bcrb_pkg::BCRB_WDATA: begin
                    if (byteDone) begin
                        state <= bcrb_pkg::BCRB_WDATA_ACK; // [RULE_06]
                    end
                end
                bcrb_pkg::BCRB_WDATA_ACK: begin
                    if (ackClocked) begin
                        state <= bcrb_pkg::BCRB_WDATA;
                    end
                end
                bcrb_pkg::BCRB_RDATA: begin
                    if (byteDone) begin
                        state <= bcrb_pkg::BCRB_RDATA_ACK;
                    end
                end
                bcrb_pkg::BCRB_RDATA_ACK: begin
                    if (ackClocked) begin
                        state <= masterAcked ? bcrb_pkg::BCRB_RDATA : bcrb_pkg::BCRB_IDLE;
                    end
                end
                default: state <= bcrb_pkg::BCRB_IDLE;
            endcase
        end
    end

    // Pointer advances after every data byte, so bursts walk the map
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pointer <= 8'h00;
        end else if (state == bcrb_pkg::BCRB_OFFSET && byteDone) begin
            pointer <= shiftIn;
        end else if (writeStrobe) begin
            pointer <= pointer + 8'h01;
        end else if (state == bcrb_pkg::BCRB_RDATA && byteDone) begin
            pointer <= pointer + 8'h01;
        end
    end

    // Transmit shifter: loaded when the master's clock falls into the data phase
    always_ff @(posedge clock) begin
        if (!resetn) begin
            shiftOut <= 8'hff;
        end else if (ackClocked && (state == bcrb_pkg::BCRB_ADDR_ACK ||
                state == bcrb_pkg::BCRB_RDATA_ACK)) begin
            shiftOut <= readByte; // [RULE_08]
        end else if (state == bcrb_pkg::BCRB_RDATA && line.sclFall) begin
            shiftOut <= {shiftOut[6:0], 1'b1};
        end
    end

    // Open drain: only ever pull low; changes happen on clock fall while scl is low
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sdaOe <= 1'b0;
        end else if (line.startSeen || line.stopSeen) begin
            sdaOe <= 1'b0;
        end else if (byteDone && ((state == bcrb_pkg::BCRB_ADDR && addressHit) ||
                state == bcrb_pkg::BCRB_OFFSET || state == bcrb_pkg::BCRB_WDATA)) begin
            sdaOe <= 1'b1; // [RULE_06]
        end else if (ackClocked && state == bcrb_pkg::BCRB_ADDR_ACK && readRequest) begin
            sdaOe <= ~readByte[7];
        end else if (ackClocked && state == bcrb_pkg::BCRB_RDATA_ACK && masterAcked) begin
            sdaOe <= ~readByte[7];
        end else if (state == bcrb_pkg::BCRB_RDATA && line.sclFall) begin
            // After the eighth bit the line is released for the master's answer
            sdaOe <= byteDone ? 1'b0 : ~shiftOut[6];
        end else if (ackClocked) begin
            sdaOe <= 1'b0;
        end
    end

    assign sdaOut = 1'b0;

    // Writable configuration; offsets past the writable range are ignored
    genvar gi;
    generate
        for (gi = 0; gi < bcrb_pkg::NUM_CFG; gi++) begin : g_cfg
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    cfg[gi] <= bcrb_pkg::CFG_RESET[gi]; // [RULE_02]
                end else if (writeStrobe && pointer == 8'(gi)) begin
                    cfg[gi] <= shiftIn; // [RULE_07]
                end
            end
        end
    endgenerate

    // Completion from the memory wins over a same-cycle write of the command
    always_ff @(posedge clock) begin
        if (!resetn) begin
            nvmCommand <= bcrb_pkg::NVM_CMD_IDLE;
        end else if (nvmWriteDone) begin
            nvmCommand <= bcrb_pkg::NVM_CMD_IDLE;
        end else if (writeStrobe && pointer == bcrb_pkg::OFS_NVM_WRITE_AND_OPEN_FLAGS) begin
            nvmCommand <= shiftIn[bcrb_pkg::NVM_CMD_MSB:bcrb_pkg::NVM_CMD_LSB];
        end
    end

    assign nvmProgramBusy = (nvmCommand == bcrb_pkg::NVM_CMD_PROGRAM);

    // Control fields of offset zero feeding the analog loop
    assign loopGainSelect = cfg[0][bcrb_pkg::LOOP_GAIN_MSB:bcrb_pkg::LOOP_GAIN_LSB]; // [RULE_03]
    assign continuousConduction = cfg[0][bcrb_pkg::BOOST_MODE_BIT]; // [RULE_04]
    assign overvoltageThresholdCode = cfg[0][bcrb_pkg::OVP_MSB:bcrb_pkg::OVP_LSB]; // [RULE_05]
    assign configRegs = cfg;
endmodule

// file: bench/bcrb_bus_master.sv
/*
 * Behavioural serial bus master that sits on the far side of the register bank.
 * Assumes a pull-up on the data line; the bench combines drivers into sdaBus.
 */
`timescale 1ns/1ns
module bcrb_bus_master (
    input wire logic clock,
    input wire logic sdaBus,
    output logic scl,
    output logic sdaDrive
);
    // HALF of six plus the aligning edge gives seven clocks a phase, well above the three-clock minimum of the slave
    localparam int HALF = 6;

    initial begin
        scl = 1'b1;
        sdaDrive = 1'b1;
    end

    task automatic hold(input logic s, input logic d);
        @(posedge clock);
        scl <= s;
        sdaDrive <= d;
        repeat (HALF) @(posedge clock);
    endtask

    // Also serves as repeated start
    task automatic start_cond();
        hold(1'b0, 1'b1);
        hold(1'b1, 1'b1);
        hold(1'b1, 1'b0);
        hold(1'b0, 1'b0);
    endtask

    task automatic stop_cond();
        hold(1'b0, 1'b0);
        hold(1'b1, 1'b0);
        hold(1'b1, 1'b1);
    endtask

    // Level sampled at the end of the high phase, where it must be stable
    task automatic bit_xfer(input logic d, output logic q);
        hold(1'b0, d);
        hold(1'b1, d);
        q = sdaBus;
    endtask

    // MSB first, ninth clock carries the acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], q);
        end
        bit_xfer(1'b1, q);
        ack = ~q;
    endtask

    task automatic recv_byte(output logic [7:0] b, input logic nack);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, b[i]);
        end
        bit_xfer(nack, q);
    endtask
endmodule

// file: bench/bcrb_top_assertions.sv
/*
 * Concurrent checks on the ports of the register bank top module.
 * Assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ns
module bcrb_top_assertions (
    input wire logic clock,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sdaOe,
    input wire logic [2:0] loopGainSelect,
    input wire logic continuousConduction,
    input wire logic [3:0] overvoltageThresholdCode,
    input wire logic [bcrb_pkg::NUM_CFG*bcrb_pkg::REG_W-1:0] configRegs
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_reset_cfg_value: assert property ($rose(resetn) |->
        configRegs[7:0] == 8'he0 && !sdaOe)
        else $error("control register not e0 after reset");
    a_gain_field_map: assert property (loopGainSelect == configRegs[7:5])
        else $error("loop gain field mismatch");
    a_boost_mode_map: assert property (continuousConduction == configRegs[4])
        else $error("boost mode bit mismatch");
    a_ovp_code_map: assert property (overvoltageThresholdCode == configRegs[3:0])
        else $error("threshold code mismatch");
    // A register update lands exactly where the acknowledge is released
    a_update_at_ackend: assert property ($changed(configRegs) |-> $fell(sdaOe))
        else $error("register changed away from acknowledge end");
    a_drive_starts_low: assert property ($rose(sdaOe) |-> !scl)
        else $error("data line pulled while clock high");
    a_stable_clock_high: assert property (scl && $past(scl) |-> $stable(sdaOe))
        else $error("data line moved during clock high");
    a_ack_held_span: assert property ($rose(sdaOe) |-> sdaOe [*3])
        else $error("acknowledge pulse too short");
endmodule

bind bcrb_top bcrb_top_assertions chk_u (
    .clock(clock),
    .resetn(resetn),
    .scl(scl),
    .sdaOe(sdaOe),
    .loopGainSelect(loopGainSelect),
    .continuousConduction(continuousConduction),
    .overvoltageThresholdCode(overvoltageThresholdCode),
    .configRegs(configRegs)
);

// file: bench/backlight_config_register_bank_test.sv
/*
 * Self-checking bench of the register bank, driven through the bus master model.
 * Assumes the master model and the checker are compiled alongside.
 */
`timescale 1ns/1ns
module backlight_config_register_bank_test;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic scl, sdaDrive, sdaOut, sdaOe, sdaBus;
    logic [1:0] addrStrap = 2'h0;
    logic [7:0] checksumLow = 8'h3c;
    logic [7:0] checksumHigh = 8'hc3;
    logic [7:0] faultFlags = 8'h5a;
    logic nvmWriteDone = 1'b0;
    logic nvmCrcOk = 1'b1;
    logic ledOpen = 1'b0;
    logic [2:0] loopGainSelect;
    logic continuousConduction, nvmProgramBusy;
    logic [3:0] overvoltageThresholdCode;
    logic [bcrb_pkg::NUM_CFG*bcrb_pkg::REG_W-1:0] configRegs;
    int err_total = 0;
    int check_count = 0;
    logic [7:0] d;
    logic ack;
    logic [7:0] vals [3] = '{8'h15, 8'hbf, 8'h0f};
    logic [7:0] ctrlFields;

    assign ctrlFields = {loopGainSelect, continuousConduction, overvoltageThresholdCode};

    // Open drain wire with pull-up
    assign sdaBus = sdaDrive & ~sdaOe;

    always #4 clock = ~clock;

    bcrb_bus_master master_u (.clock(clock), .sdaBus(sdaBus), .scl(scl), .sdaDrive(sdaDrive));

    bcrb_top dut_u (.clock(clock), .resetn(resetn), .scl(scl), .sdaIn(sdaBus),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrap(addrStrap), .checksumLow(checksumLow),
        .checksumHigh(checksumHigh), .faultFlags(faultFlags), .nvmWriteDone(nvmWriteDone),
        .nvmCrcOk(nvmCrcOk), .ledOpen(ledOpen), .loopGainSelect(loopGainSelect),
        .continuousConduction(continuousConduction),
        .overvoltageThresholdCode(overvoltageThresholdCode), .configRegs(configRegs),
        .nvmProgramBusy(nvmProgramBusy));

    task automatic end_of_test();
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
        master_u.start_cond();
        master_u.send_byte(8'h60, ack);
        chk1(ack, 1'b1);
        master_u.send_byte(ofs, ack);
        chk1(ack, 1'b1);
        master_u.send_byte(dat, ack);
        chk1(ack, 1'b1);
        chk1(sdaOut, 1'b0);
        master_u.stop_cond();
    endtask

    task automatic rd(input logic [7:0] ofs, output logic [7:0] dat);
        master_u.start_cond();
        master_u.send_byte(8'h60, ack);
        master_u.send_byte(ofs, ack);
        master_u.start_cond();
        master_u.send_byte(8'h61, ack);
        chk1(ack, 1'b1);
        master_u.recv_byte(dat, 1'b1);
        master_u.stop_cond();
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        chk8(ctrlFields, 8'he0);
        for (int i = 0; i < bcrb_pkg::NUM_CFG; i++) begin
            rd(i[7:0], d);
            chk8(d, bcrb_pkg::CFG_RESET[i]);
        end
        // Neighbouring address must be ignored
        master_u.start_cond();
        master_u.send_byte(8'h62, ack);
        chk1(ack, 1'b0);
        master_u.stop_cond();
        foreach (vals[i]) begin
            wr(8'h00, vals[i]);
            chk8(ctrlFields, vals[i]);
            rd(8'h00, d);
            chk8(d, vals[i]);
        end
        wr(8'h05, 8'ha5);
        chk8(configRegs[47:40], 8'ha5);
        wr(8'h10, 8'h12);
        rd(8'h10, d);
        chk8(d, 8'hff);
        rd(8'h3f, d);
        chk8(d, 8'hff);
        // Read-only places keep showing their live inputs
        wr(8'h0c, 8'h00);
        rd(8'h0c, d);
        chk8(d, checksumLow);
        rd(8'h0d, d);
        chk8(d, checksumHigh);
        rd(8'h0e, d);
        chk8(d, faultFlags);
        wr(8'h0f, 8'h90);
        chk1(nvmProgramBusy, 1'b1);
        rd(8'h0f, d);
        chk8(d, 8'h92);
        @(posedge clock);
        nvmWriteDone <= 1'b1;
        @(posedge clock);
        nvmWriteDone <= 1'b0;
        repeat (2) @(posedge clock);
        chk1(nvmProgramBusy, 1'b0);
        end_of_test();
    end
endmodule
